// *** design/latch_move_exec.sv ***
// four-phase executor for the table-latch read and peripheral move
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - latch read writes one latch byte to file
// - select one takes high byte, zero low
// - latch read leaves latch contents untouched
// - opcode 1010 00 t x plus file address
// - latch read takes one cycle, Q1 to Q4
// - latch read touches no status flag
// - peripheral move decodes, reads, executes, writes
// - move source spans FFh, destination 1Fh
module latch_move_exec
    import latch_move_pkg::*;
(
    input  wire logic        core_clk,    // core clock
    input  wire logic        resetn,      // synchronous reset, active low
    input  wire logic [15:0] opcode,      // instruction word, held over cycle
    input  wire logic        latch_load,  // program table read loads latch
    input  wire logic [15:0] latch_data,  // word from program memory
    input  wire logic [7:0]  file_rdata,  // data read from file at file_raddr
    output logic [7:0]       file_raddr,  // file read address
    output file_wr_s         file_wr,     // file write port
    output logic [15:0]      prog_table_latch, // table latch contents
    output logic [1:0]       phase,       // current q phase
    output logic             status_we,   // status flag write, always low here
    output logic             instr_done   // pulse at end of executed instruction
);

    // all state of this block
    typedef struct packed {
        phase_e      ph;      // q phase
        logic [15:0] ir;      // opcode captured in Q1
        decode_s     dec;     // decoded fields
        logic [7:0]  opnd;    // operand read in Q2
        logic [7:0]  result;  // value formed in Q3
        logic [15:0] latch;   // table latch
        logic [7:0]  raddr;   // read address out
        file_wr_s    wr;      // write port out
        logic        done;    // done pulse
    } state_s;

    state_s  cur;       // registered state
    state_s  next_cur;  // next state
    decode_s dec_w;     // decoder output

    // decode the opcode presented this cycle
    instr_decode u_dec
    (
        .opcode (opcode),
        .dec    (dec_w)
    );

    // byte picker shared by read phase and checks
    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic s);
        pick_byte = s ? w[15:8] : w[7:0];
    endfunction : pick_byte

    // sequencer and datapath
    always_comb
    begin
        next_cur      = cur;
        next_cur.wr   = '0;
        next_cur.done = 1'b0;
        // a table read reloads the latch; the latch read itself never writes it
        if (latch_load)
        begin
            next_cur.latch = latch_data;
        end
        unique case (cur.ph)
            PH_Q1:
            begin
                // decode
                next_cur.ir    = opcode;
                next_cur.dec   = dec_w;
                next_cur.raddr = dec_w.src;
                next_cur.ph    = PH_Q2;
            end
            PH_Q2:
            begin
                // read operand: latch byte or source file
                if (cur.dec.op == OP_LATCH)
                begin
                    next_cur.opnd = pick_byte(cur.latch, cur.dec.sel);
                end
                else
                begin
                    next_cur.opnd = file_rdata;
                end
                next_cur.ph = PH_Q3;
            end
            PH_Q3:
            begin
                // execute: plain move, no alu so no flags
                next_cur.result = cur.opnd;
                next_cur.ph     = PH_Q4;
            end
            PH_Q4:
            begin
                // write destination for the recognised instructions
                if (cur.dec.op != OP_NONE)
                begin
                    next_cur.wr.en   = 1'b1;
                    next_cur.wr.addr = cur.dec.dst;
                    next_cur.wr.data = cur.result;
                    next_cur.done    = 1'b1;
                end
                next_cur.ph = PH_Q1;
            end
        endcase
        if (!resetn)
        begin
            next_cur       = '0;
            next_cur.ph    = PH_Q1;
            next_cur.ir    = OPCODE_RESET;
            next_cur.latch = LATCH_RESET;
            next_cur.raddr = FILE_RESET;
        end
    end

    // single state register
    always_ff @(posedge core_clk)
    begin
        cur <= next_cur;
    end

    // outputs straight from flip-flops; status_we is tied low
    assign file_raddr       = cur.raddr;
    assign file_wr          = cur.wr;
    assign prog_table_latch = cur.latch;
    assign phase            = cur.ph;
    assign status_we        = 1'b0;
    assign instr_done       = cur.done;

    // checks
    sequence s_latch_issue;
        cur.ph == PH_Q1 && dec_w.op == OP_LATCH && !latch_load;
    endsequence

    sequence s_move_issue;
        cur.ph == PH_Q1 && dec_w.op == OP_MOVE;
    endsequence

    // every instruction walks Q1 to Q4 with no stall
    a_phase_order: assert property (@(posedge core_clk) disable iff (!resetn)
        cur.ph == PH_Q1 |=> cur.ph == PH_Q2 ##1 cur.ph == PH_Q3 ##1 cur.ph == PH_Q4)
        else $error("q phases out of order");

    // latch read lands the picked byte at the file address
    a_latch_write: assert property (@(posedge core_clk) disable iff (!resetn)
        s_latch_issue |-> ##4 (file_wr.en && file_wr.addr == $past(opcode[7:0], 4)
        && file_wr.data == pick_byte($past(cur.latch, 3), $past(opcode[TLR_SEL_POS], 4))))
        else $error("latch read wrote wrong byte or address");

    // only a table read may change the latch
    a_latch_kept: assert property (@(posedge core_clk) disable iff (!resetn)
        !latch_load |=> $stable(cur.latch))
        else $error("latch changed without table read");

    // select one takes the high byte in Q2
    a_hi_select: assert property (@(posedge core_clk) disable iff (!resetn)
        (cur.ph == PH_Q2 && cur.dec.op == OP_LATCH && cur.dec.sel)
        |=> cur.opnd == $past(cur.latch[15:8]))
        else $error("high byte not selected");

    // bit 8 is a don't-care, so only bits 15:10 are matched
    a_decode_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        (cur.ph == PH_Q1 && opcode[15:10] == 6'h28) |=> cur.dec.op == OP_LATCH)
        else $error("latch read not decoded");

    // neither move touches the arithmetic flags
    a_no_status: assert property (@(posedge core_clk) disable iff (!resetn)
        !status_we)
        else $error("status written");

    // move writes its five-bit destination four edges after issue
    a_move_write: assert property (@(posedge core_clk) disable iff (!resetn)
        s_move_issue |-> ##4 (file_wr.en && file_wr.addr == {3'h0, $past(opcode[12:8], 4)}))
        else $error("move destination wrong");

    // destination never leaves 00h..1Fh
    a_move_dst_range: assert property (@(posedge core_clk) disable iff (!resetn)
        (file_wr.en && cur.dec.op == OP_MOVE) |-> file_wr.addr[7:5] == 3'h0)
        else $error("move destination above 1Fh");

    // done follows Q4, so one instruction takes one cycle
    a_one_cycle: assert property (@(posedge core_clk) disable iff (!resetn)
        instr_done |-> $past(cur.ph) == PH_Q4)
        else $error("done outside Q4");

    // low byte path, the mirror of the high byte check
    a_lo_select: assert property (@(posedge core_clk) disable iff (!resetn)
        (cur.ph == PH_Q2 && cur.dec.op == OP_LATCH && !cur.dec.sel)
        |=> cur.opnd == $past(cur.latch[7:0]))
        else $error("low byte not selected");

    // move operand is taken from the file in Q2
    sequence s_move_read;
        cur.ph == PH_Q2 && cur.dec.op == OP_MOVE;
    endsequence

    a_move_data: assert property (@(posedge core_clk) disable iff (!resetn)
        s_move_read |-> ##3 (file_wr.en && file_wr.data == $past(file_rdata, 3)))
        else $error("move data not the source byte");

    // the read address names the move source, anywhere in 00h..FFh
    a_move_src: assert property (@(posedge core_clk) disable iff (!resetn)
        s_move_issue |=> file_raddr == $past(opcode[7:0]))
        else $error("move source address wrong");

    // an unrecognised word runs its phases but writes nothing
    a_refused_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
        (cur.ph == PH_Q1 && dec_w.op == OP_NONE) |-> ##4 !file_wr.en)
        else $error("refused opcode wrote a file");

    // done marks the same cycle as the destination write
    a_done_pairs: assert property (@(posedge core_clk) disable iff (!resetn)
        instr_done == file_wr.en)
        else $error("done and write strobe apart");

endmodule : latch_move_exec
`default_nettype wire

// *** inc/latch_move_pkg.sv ***
// package for the table-latch read and peripheral move executor
package latch_move_pkg;

    localparam logic [3:0]  TLR_OP_NIB     = 4'hA;     // upper nibble of latch read
    localparam logic [1:0]  TLR_ZERO_BITS  = 2'h0;     // bits 11:10 of latch read
    localparam int          TLR_SEL_POS    = 9;        // byte-select bit position
    localparam logic [2:0]  MOVE_OP_TOP    = 3'h3;     // bits 15:13 of peripheral move
    localparam int          MOVE_DST_LSB   = 8;        // dest field 12:8
    localparam logic [7:0]  FILE_RESET     = 8'h00;    // file read address reset value
    localparam logic [15:0] LATCH_RESET    = 16'h0000; // latch reset value
    localparam logic [15:0] OPCODE_RESET   = 16'h0000; // latched opcode reset value

    // q phase sequencer, gray coded
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } phase_e;

    // decoded operation
    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_LATCH = 2'b01,
        OP_MOVE  = 2'b11
    } op_e;

    // data memory write port
    typedef struct packed {
        logic       en;    // write strobe
        logic [7:0] addr;  // file address
        logic [7:0] data;  // write data
    } file_wr_s;

    // instruction decode result
    typedef struct packed {
        op_e        op;    // operation
        logic       sel;   // latch byte select
        logic [7:0] src;   // source file address
        logic [7:0] dst;   // destination file address
    } decode_s;

endpackage : latch_move_pkg

// *** design/instr_decode.sv ***
// combinational opcode decoder for the two move instructions
`timescale 1ns/1ps
`default_nettype none
module instr_decode
    import latch_move_pkg::*;
(
    input  wire logic [15:0] opcode,  // instruction word
    output decode_s          dec      // decoded fields
);
    // latch read: 1010 00 t x ffffffff; peripheral move: 011p pppp ffff ffff
    always_comb
    begin
        dec.op  = OP_NONE;
        dec.sel = opcode[TLR_SEL_POS];
        dec.src = opcode[7:0];
        dec.dst = opcode[7:0];
        if (opcode[15:12] == TLR_OP_NIB && opcode[11:10] == TLR_ZERO_BITS)
        begin
            dec.op = OP_LATCH;
        end
        else if (opcode[15:13] == MOVE_OP_TOP)
        begin
            dec.op  = OP_MOVE;
            // destination only reaches 00h..1Fh
            dec.dst = {3'h0, opcode[MOVE_DST_LSB +: 5]};
        end
    end
endmodule : instr_decode
`default_nettype wire

// *** dv/table_latch_move_instructions_tb_top.sv ***
// self-checking bench for the latch read and peripheral move executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module table_latch_move_instructions_tb_top
    import latch_move_pkg::*;
;
    logic        core_clk = 1'b0;  // 250 MHz core clock
    logic        resetn   = 1'b0;  // synchronous reset, active low
    logic [15:0] opcode   = 16'h0000; // instruction word
    logic        latch_load = 1'b0;   // table read hook
    logic [15:0] latch_data = 16'h0000; // word for the latch
    logic [7:0]  file_rdata;       // file data, combinational from mem
    logic [7:0]  file_raddr;       // file read address
    file_wr_s    file_wr;          // file write port
    logic [15:0] prog_table_latch; // latch contents
    logic [1:0]  phase;            // q phase
    logic        status_we;        // status flag write
    logic        instr_done;       // end of instruction pulse
    logic [7:0]  mem [256];        // static file image, never written back
    logic [15:0] lat = 16'h0000;   // expected latch contents
    logic [15:0] corner [9] = '{16'hA0FF, 16'hA2FF, 16'hA100, 16'hA300, 16'h7FFF,
                                16'h6000, 16'hA400, 16'h0000, 16'hFFFF};
    int          seed = 32'h58F0;  // fixed seed, repeatable run
    int          failures = 0;     // mismatch count
    int          n_tests = 0;      // comparison count
    // file reads answer at once, as a register file would
    assign file_rdata = mem[file_raddr];
    // clock: 2 ns half period
    always #2 core_clk = ~core_clk;
    latch_move_exec u_dut (
        .core_clk         (core_clk),
        .resetn           (resetn),
        .opcode           (opcode),
        .latch_load       (latch_load),
        .latch_data       (latch_data),
        .file_rdata       (file_rdata),
        .file_raddr       (file_raddr),
        .file_wr          (file_wr),
        .prog_table_latch (prog_table_latch),
        .phase            (phase),
        .status_we        (status_we),
        .instr_done       (instr_done)
    );
    // expected write for one opcode; refused words give no strobe
    function automatic file_wr_s expect_wr(input logic [15:0] op);
        expect_wr = '0;
        if (op[15:10] == 6'b101000)
        begin
            expect_wr = '{1'b1, op[7:0], op[9] ? lat[15:8] : lat[7:0]};
        end
        else if (op[15:13] == 3'b011)
        begin
            expect_wr = '{1'b1, {3'h0, op[12:8]}, mem[op[7:0]]};
        end
    endfunction : expect_wr
    // one instruction from Q1 to the write; entered at a falling edge in Q1
    task automatic run_instr(input logic [15:0] op, input logic load);
        file_wr_s exp;
        opcode     = op;
        latch_load = load;
        latch_data = 16'($random(seed));
        // a load at the taking edge lands before the Q2 byte pick
        if (load)
            lat = latch_data;
        exp = expect_wr(op);
        @(negedge core_clk);
        latch_load = 1'b0;
        `CHK("phase", 2'h1, phase)
        `CHK("wr_stand", 1'b0, file_wr.en)
        if (op[15:13] == 3'b011)
        begin
            `CHK("raddr", op[7:0], file_raddr)
        end
        repeat (3) @(negedge core_clk);
        `CHK("wr_en", exp.en, file_wr.en)
        `CHK("done", exp.en, instr_done)
        // address and data only mean something under the strobe
        if (exp.en)
        begin
            `CHK("wr_addr", exp.addr, file_wr.addr)
            `CHK("wr_data", exp.data, file_wr.data)
        end
        `CHK("latch", lat, prog_table_latch)
        `CHK("status", 1'b0, status_we)
    endtask : run_instr
    // verdict and end of run
    task automatic test_done();
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // watchdog, far beyond the ~210 instructions of 16 ns each
    initial
    begin
        #40000;
        failures++;
        test_done();
    end
    // main sequence: reset, corners, then random traffic
    initial
    begin
        logic [15:0] r;
        foreach (mem[i])
            mem[i] = 8'($random(seed));
        repeat (2) @(negedge core_clk);
        `CHK("rst_phase", 2'h0, phase)
        `CHK("rst_latch", 16'h0000, prog_table_latch)
        resetn = 1'b1;
        foreach (corner[i])
            run_instr(corner[i], i == 0);
        repeat (200)
        begin
            r = 16'($random(seed));
            case (r[15:14])
                2'h0: run_instr({6'b101000, r[9:0]}, r[13]);
                2'h1: run_instr({3'b011, r[12:0]}, r[13]);
                default: run_instr(r, r[13]);
            endcase
        end
        // reset in mid-instruction: the cut latch read must not write
        opcode = 16'hA2FF;
        @(negedge core_clk);
        resetn = 1'b0;
        lat    = LATCH_RESET;
        repeat (2) @(negedge core_clk);
        `CHK("rst2_phase", 2'h0, phase)
        `CHK("rst2_wr", 1'b0, file_wr.en)
        `CHK("rst2_latch", lat, prog_table_latch)
        resetn = 1'b1;
        run_instr(16'hA2FF, 1'b0);
        test_done();
    end
endmodule : table_latch_move_instructions_tb_top
`default_nettype wire
